/* File: rtl/flash_sp_regs.svh */
// register map, field positions, command codes and timing of the sequencer
`ifndef FLASH_SP_REGS_SVH
`define FLASH_SP_REGS_SVH
// Summary of operation
// - While self-programming, any pending unmasked interrupt request flag stops the operation at once.
// - Only unmasked requests stop it, whatever the global interrupt enable is; masked ones do not.
// - After a stop, software returns to normal mode and services the interrupt, then may re-enter and the device resumes the stopped operation.
// - The operation runs on the high-speed oscillator timing, and a stabilization wait passes inside the operation when the CPU runs from the crystal or external clock.
// - Boot cluster 0 is 0000H-0FFFH and cluster 1 is 1000H-1FFFH, each 4 KB.
// - After a reset with the swap flag set, addresses 0000H-0FFFH reach cluster 1.
// - The set-information function swaps clusters 0 and 1 on request and restores them on a later request.
// - The swap selection is retained through power loss and applied at the next reset.
// - With cluster 0 protection on, batch erase, block erase and write to cluster 0 are refused.
// - Block-erase and write protections bind only the external programmer, not self-programming.

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_WDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_SECURITY 8'h14
`define REG_EVENT 8'h18
`define REG_EVMASK 8'h1C

// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_SP_MODE 0
`define SEC_BOOT0 0
`define SEC_BLK_ERASE 1
`define SEC_WRITE 2
`define ST_BUSY 0
`define ST_HALTED 1
`define ST_SWAP_ACTIVE 2
`define ST_SWAP_NV 3
`define ST_FMODE_PIN 4
`define EV_DONE 0
`define EV_ABORT 1
`define EV_REFUSED 2
`define EV_BITS 3
`define SEC_BITS 3

// ----------------------------------------
// commands, written to the low bits of the command register
// ----------------------------------------
`define CMD_BLOCK_ERASE 3'h1
`define CMD_WRITE 3'h2
`define CMD_BATCH_ERASE 3'h3
`define CMD_SWAP_SET 3'h4
`define CMD_SWAP_CLR 3'h5
`define CMD_RESUME 3'h6

// ----------------------------------------
// address decode and timing
// ----------------------------------------
`define CLUSTER_BIT 12
`define BOOT_C0_PAGE 4'h0
`define BOOT_C1_PAGE 4'h1
`define CLK_PERIOD_NS 10
`define OSC_STAB_NS 2000
`define OSC_STAB_CYC ((`OSC_STAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_DIV 4
`endif

/* File: rtl/flash_sp_pkg.sv */
// types shared by the flash self-programming sequencer
package flash_sp_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_WAIT = 4'h2,
        S_RUN = 4'h4,
        S_HALT = 4'h8
    } seq_state_t;
endpackage

/* File: rtl/osc_timing_if.sv */
// oscillator timing link between sequencer and timer
interface osc_timing_if;
    logic start_wait;
    logic need_stab;
    logic wait_done;
    logic osc_tick;
    modport seq (output start_wait, output need_stab, input wait_done,
                 input osc_tick);
    modport timer (input start_wait, input need_stab, output wait_done,
                   output osc_tick);
endinterface

/* File: rtl/osc_timer.sv */
// high-speed oscillator step enable and stabilization wait counter
`include "flash_sp_regs.svh"
module osc_timer
#(
    parameter int STAB_CYC = `OSC_STAB_CYC,
    parameter int DIV = `OSC_DIV
)
(
    input wire logic ref_clk,
    input wire logic srst,
    osc_timing_if.timer t
);
    logic [15:0] div_r;
    logic [15:0] wait_r;
    logic busy_r;

    // ----------------------------------------
    // step enable
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || div_r == 16'(DIV - 1))
            div_r <= 16'h0000;
        else
            div_r <= div_r + 16'h0001;
    end
    assign t.osc_tick = (div_r == 16'(DIV - 1));

    // ----------------------------------------
    // stabilization wait
    // ----------------------------------------
    // wait is skipped when the cpu already runs from the oscillator
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wait_r <= 16'h0000;
            busy_r <= 1'b0;
        end
        else if (t.start_wait)
        begin
            wait_r <= t.need_stab ? 16'(STAB_CYC) : 16'h0000;
            busy_r <= 1'b1;
        end
        else if (wait_r != 16'h0000)
            wait_r <= wait_r - 16'h0001;
    end
    assign t.wait_done = busy_r && (wait_r == 16'h0000) && !t.start_wait;
endmodule

/* File: rtl/flash_self_program.sv */
// flash self-programming sequencer with boot cluster swap
`include "flash_sp_regs.svh"
module flash_self_program
    import flash_sp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] irq_flag_group0_low,
    input wire logic [7:0] irq_flag_group0_high,
    input wire logic [7:0] irq_flag_group1_low,
    input wire logic [7:0] irq_flag_group1_high,
    input wire logic [7:0] irq_mask_group0_low,
    input wire logic [7:0] irq_mask_group0_high,
    input wire logic [7:0] irq_mask_group1_low,
    input wire logic [7:0] irq_mask_group1_high,
    input wire logic flash_mode_select_pin,
    input wire logic crystal_main_clock,
    input wire logic ext_prog_mode,
    input wire logic boot_swap_nv,
    input wire logic [15:0] cpu_addr,
    output logic [15:0] phys_addr,
    output logic flash_req,
    output logic [2:0] flash_op,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    input wire logic flash_ack,
    output logic irq
);
    seq_state_t state_r;
    logic sp_mode_r;
    logic [2:0] op_r;
    logic [15:0] addr_r;
    logic [7:0] wdata_r;
    logic [`SEC_BITS-1:0] sec_r;
    logic [`EV_BITS-1:0] ev_r;
    logic [`EV_BITS-1:0] evmask_r;
    logic swap_active_r;
    logic swap_nv_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [15:0] phys_addr_r;
    logic wr_acc;
    logic cmd_wr;
    logic [2:0] cmd;
    logic pending;
    logic to_c0;
    logic refuse;
    logic start_ok;
    logic resume_ok;
    logic abort_now;
    logic done_now;
    logic [`EV_BITS-1:0] ev_set;
    logic mapped;
    logic [31:0] rd_val;
    osc_timing_if tif ();

    osc_timer osc_timer_inst (
        .ref_clk(ref_clk),
        .srst(srst),
        .t(tif.timer)
    );

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // zero wait: read data is latched in the setup cycle
    assign wr_acc = psel && penable && pwrite;
    assign cmd_wr = wr_acc && paddr == `REG_CMD;
    assign cmd = pwdata[2:0];
    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `REG_CTRL: rd_val[`CTRL_SP_MODE] = sp_mode_r;
            `REG_CMD: rd_val = 32'h0000_0000;
            `REG_ADDR: rd_val[15:0] = addr_r;
            `REG_WDATA: rd_val[7:0] = wdata_r;
            `REG_STATUS:
            begin
                rd_val[`ST_BUSY] = (state_r != S_IDLE);
                rd_val[`ST_HALTED] = (state_r == S_HALT);
                rd_val[`ST_SWAP_ACTIVE] = swap_active_r;
                rd_val[`ST_SWAP_NV] = swap_nv_r;
                rd_val[`ST_FMODE_PIN] = flash_mode_select_pin;
            end
            `REG_SECURITY: rd_val[`SEC_BITS-1:0] = sec_r;
            `REG_EVENT: rd_val[`EV_BITS-1:0] = ev_r;
            `REG_EVMASK: rd_val[`EV_BITS-1:0] = evmask_r;
            default: mapped = 1'b0;
        endcase
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_r <= !mapped;
        end
    end
    assign prdata = prdata_r;
    assign pslverr = pslverr_r && psel && penable;
    assign pready = 1'b1;

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            sp_mode_r <= 1'b0;
        else if (wr_acc && paddr == `REG_CTRL)
            sp_mode_r <= pwdata[`CTRL_SP_MODE];
    end
    // protection bits only ever set from this side
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            sec_r <= 3'h0;
        else if (wr_acc && paddr == `REG_SECURITY)
            sec_r <= sec_r | pwdata[`SEC_BITS-1:0];
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            evmask_r <= 3'h0;
        else if (wr_acc && paddr == `REG_EVMASK)
            evmask_r <= pwdata[`EV_BITS-1:0];
    end
    // operands frozen while busy so a resume repeats the same job
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
        end
        else if (state_r == S_IDLE && wr_acc)
        begin
            if (paddr == `REG_ADDR)
                addr_r <= pwdata[15:0];
            if (paddr == `REG_WDATA)
                wdata_r <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // abort detection and command checks
    // ----------------------------------------
    // the global enable is deliberately not consulted
    assign pending = |({irq_flag_group1_high, irq_flag_group1_low,
                        irq_flag_group0_high, irq_flag_group0_low}
                     & ~{irq_mask_group1_high, irq_mask_group1_low,
                         irq_mask_group0_high, irq_mask_group0_low});
    assign to_c0 = addr_r[15:12] == `BOOT_C0_PAGE;
    always_comb
    begin
        refuse = 1'b0;
        unique case (cmd)
            `CMD_BATCH_ERASE:
                refuse = sec_r[`SEC_BOOT0];
            `CMD_BLOCK_ERASE:
                refuse = (sec_r[`SEC_BOOT0] && to_c0)
                      || (ext_prog_mode && sec_r[`SEC_BLK_ERASE]);
            `CMD_WRITE:
                refuse = (sec_r[`SEC_BOOT0] && to_c0)
                      || (ext_prog_mode && sec_r[`SEC_WRITE]);
            `CMD_SWAP_SET, `CMD_SWAP_CLR: refuse = 1'b0;
            default: refuse = 1'b1;
        endcase
    end
    assign start_ok = cmd_wr && state_r == S_IDLE && sp_mode_r
                   && flash_mode_select_pin && !refuse;
    assign resume_ok = cmd_wr && cmd == `CMD_RESUME && state_r == S_HALT
                    && sp_mode_r && flash_mode_select_pin;
    assign abort_now = (state_r == S_WAIT || state_r == S_RUN) && pending;
    assign done_now = state_r == S_RUN && flash_ack && !pending;
    assign tif.start_wait = start_ok || resume_ok;
    assign tif.need_stab = crystal_main_clock;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            state_r <= S_IDLE;
        else
        begin
            unique case (state_r)
                S_IDLE:
                    if (start_ok)
                        state_r <= S_WAIT;
                S_WAIT:
                    if (pending)
                        state_r <= S_HALT;
                    else if (tif.wait_done && tif.osc_tick)
                        state_r <= S_RUN;
                S_RUN:
                    if (pending)
                        state_r <= S_HALT;
                    else if (flash_ack)
                        state_r <= S_IDLE;
                S_HALT:
                    if (resume_ok)
                        state_r <= S_WAIT;
                default: state_r <= S_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            op_r <= 3'h0;
        else if (start_ok)
            op_r <= cmd;
    end
    assign flash_req = state_r == S_RUN;
    assign flash_op = op_r;
    assign flash_addr = addr_r;
    assign flash_wdata = wdata_r;

    // ----------------------------------------
    // boot swap
    // ----------------------------------------
    // the retained flag lives in the flash info area; its copy here
    // follows each completed set-information job
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            swap_nv_r <= boot_swap_nv;
        else if (done_now && op_r == `CMD_SWAP_SET)
            swap_nv_r <= 1'b1;
        else if (done_now && op_r == `CMD_SWAP_CLR)
            swap_nv_r <= 1'b0;
    end
    // the mapping only changes at reset, never mid-run
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            swap_active_r <= boot_swap_nv;
    end
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            phys_addr_r <= 16'h0000;
        else
        begin
            phys_addr_r <= cpu_addr;
            if (swap_active_r && (cpu_addr[15:12] == `BOOT_C0_PAGE
                               || cpu_addr[15:12] == `BOOT_C1_PAGE))
                phys_addr_r[`CLUSTER_BIT] <= !cpu_addr[`CLUSTER_BIT];
        end
    end
    assign phys_addr = phys_addr_r;

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    assign ev_set = {cmd_wr && !start_ok && !resume_ok,
                     abort_now, done_now};
    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ev_r <= 3'h0;
        else if (wr_acc && paddr == `REG_EVENT)
            ev_r <= (ev_r & ~pwdata[`EV_BITS-1:0]) | ev_set;
        else
            ev_r <= ev_r | ev_set;
    end
    assign irq = |(ev_r & evmask_r);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_abort_on_pending;
        (state_r == S_RUN || state_r == S_WAIT) && pending
            |=> state_r == S_HALT && !flash_req && ev_r[`EV_ABORT];
    endproperty
    a_abort_on_pending: assert property (p_abort_on_pending)
        else $error("pending interrupt did not stop the job");

    property p_masked_ignored;
        state_r == S_RUN && !pending && !flash_ack |=> state_r == S_RUN;
    endproperty
    a_masked_ignored: assert property (p_masked_ignored)
        else $error("job stopped without an unmasked request");

    property p_resume_restarts;
        resume_ok |=> state_r == S_WAIT ##0 flash_op == $past(flash_op);
    endproperty
    a_resume_restarts: assert property (p_resume_restarts)
        else $error("resume did not restart the stopped job");

    property p_no_req_in_wait;
        state_r == S_WAIT && !pending |-> !flash_req
            ##[1:260] (state_r != S_WAIT);
    endproperty
    a_no_req_in_wait: assert property (p_no_req_in_wait)
        else $error("oscillator wait wrong");

    property p_swap_decode;
        swap_active_r && cpu_addr[15:12] == `BOOT_C0_PAGE
            |=> phys_addr[15:12] == `BOOT_C1_PAGE
             && phys_addr[11:0] == $past(cpu_addr[11:0]);
    endproperty
    a_swap_decode: assert property (p_swap_decode)
        else $error("cluster 0 address not sent to cluster 1");

    property p_boot0_refused;
        cmd_wr && state_r == S_IDLE && sec_r[`SEC_BOOT0]
            && (cmd == `CMD_BATCH_ERASE || (to_c0 && cmd == `CMD_WRITE))
            |=> state_r == S_IDLE ##0 ev_r[`EV_REFUSED];
    endproperty
    a_boot0_refused: assert property (p_boot0_refused)
        else $error("cluster 0 job not refused");

    property p_selfprog_unprotected;
        cmd_wr && state_r == S_IDLE && sp_mode_r && flash_mode_select_pin
            && !ext_prog_mode && !to_c0 && cmd == `CMD_WRITE
            |=> state_r == S_WAIT;
    endproperty
    a_selfprog_unprotected: assert property (p_selfprog_unprotected)
        else $error("self-programming write was blocked");

    property p_swap_set;
        done_now && op_r == `CMD_SWAP_SET |=> swap_nv_r
            ##1 $stable(swap_active_r);
    endproperty
    a_swap_set: assert property (p_swap_set)
        else $error("swap request not retained");

    property p_halt_holds;
        state_r == S_HALT && !resume_ok |=> state_r == S_HALT
            && !flash_req && (!ev_r[`EV_DONE] || $past(ev_r[`EV_DONE]));
    endproperty
    a_halt_holds: assert property (p_halt_holds)
        else $error("halted job left halt without resume");
endmodule

/* File: tb/flash_array_model.sv */
// flash array stand-in that holds the retained boot swap flag
module flash_array_model
(
    input wire logic ref_clk,
    input wire logic flash_req,
    input wire logic [2:0] flash_op,
    input wire logic [7:0] delay,
    output logic flash_ack,
    output logic boot_swap_nv
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    initial flash_ack = 1'b0;
    initial boot_swap_nv = 1'b0;
    // ------------------------------------
    // job completion
    // ------------------------------------
    // no reset here: the swap flag must survive any device reset
    always @(posedge ref_clk)
    begin
        if (flash_ack)
        begin
            flash_ack <= 1'b0;
            cnt <= 8'h00;
        end
        else if (flash_req && cnt >= delay)
        begin
            flash_ack <= 1'b1;
            if (flash_op == 3'h4)
                boot_swap_nv <= 1'b1;
            if (flash_op == 3'h5)
                boot_swap_nv <= 1'b0;
        end
        else if (flash_req)
            cnt <= cnt + 8'h01;
        else
            cnt <= 8'h00;
    end
endmodule

/* File: tb/flash_self_program_boot_swap_test.sv */
// self-checking bench of the flash self-programming sequencer
`include "flash_sp_regs.svh"
module flash_self_program_boot_swap_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, flash_req, flash_ack, boot_swap_nv;
    logic [3:0][7:0] flg = '0;
    logic [3:0][7:0] msk = '0;
    logic pin = 1'b1;
    logic xtal = 1'b0;
    logic ext = 1'b0;
    logic [15:0] cpu_addr = 16'h0;
    logic [15:0] phys_addr, flash_addr;
    logic [2:0] flash_op;
    logic [7:0] flash_wdata;
    logic [7:0] delay = 8'h04;
    logic [31:0] rd;
    logic er;
    int n;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] din [3] = '{16'h0123, 16'h1ABC, 16'h2345};
    logic [15:0] dsw [3] = '{16'h1123, 16'h0ABC, 16'h2345};
    logic px [7] = '{0, 0, 0, 0, 0, 1, 1};
    logic [2:0] pc [7] = '{`CMD_WRITE, `CMD_BLOCK_ERASE, `CMD_BATCH_ERASE,
        `CMD_BLOCK_ERASE, `CMD_WRITE, `CMD_BLOCK_ERASE, `CMD_WRITE};
    logic [15:0] pa [7] = '{16'h0100, 16'h0800, 16'h0, 16'h2000, 16'h2000,
        16'h2000, 16'h3000};
    logic [2:0] pe [7] = '{3'h4, 3'h4, 3'h4, 3'h1, 3'h1, 3'h4, 3'h4};

    always #5 ref_clk = ~ref_clk;

    flash_self_program flash_self_program_inst (.ref_clk(ref_clk),
        .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_flag_group0_low(flg[0]),
        .irq_flag_group0_high(flg[1]), .irq_flag_group1_low(flg[2]),
        .irq_flag_group1_high(flg[3]), .irq_mask_group0_low(msk[0]),
        .irq_mask_group0_high(msk[1]), .irq_mask_group1_low(msk[2]),
        .irq_mask_group1_high(msk[3]), .flash_mode_select_pin(pin),
        .crystal_main_clock(xtal), .ext_prog_mode(ext),
        .boot_swap_nv(boot_swap_nv), .cpu_addr(cpu_addr),
        .phys_addr(phys_addr), .flash_req(flash_req), .flash_op(flash_op),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_ack(flash_ack), .irq(irq));

    flash_array_model flash_array_model_inst (.ref_clk(ref_clk),
        .flash_req(flash_req), .flash_op(flash_op), .delay(delay),
        .flash_ack(flash_ack), .boot_swap_nv(boot_swap_nv));

    // ------------------------------------
    // helpers
    // ------------------------------------
    task close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // hold until pready is seen; the bench timeout bounds a hang
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask

    task job(input logic [2:0] c, input logic [15:0] a);
        wr(`REG_ADDR, 32'(a));
        wr(`REG_WDATA, 32'hA5);
        wr(`REG_CMD, 32'(c));
    endtask

    task wait_ev();
        int k;
        k = 0;
        rd = 32'h0;
        while (rd[2:0] == 3'h0 && k < 300)
        begin
            apb(1'b0, `REG_EVENT, 32'h0);
            k++;
        end
        if (rd[2:0] == 3'h0)
            mismatches++;
    endtask

    task wait_req();
        n = 0;
        while (flash_req !== 1'b1 && n < 1000)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000)
            mismatches++;
    endtask

    task do_reset();
        srst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
    endtask

    // ------------------------------------
    // scenarios
    // ------------------------------------
    initial
    begin
        do_reset();
        rdchk(`REG_STATUS, 32'hFFFFFFFF, 32'h10);
        rdchk(`REG_EVENT, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({er, rd[30:0]}, 32'h80000000);
        cpu_addr <= 16'h0ABC;
        repeat (2) @(posedge ref_clk);
        check(32'(phys_addr), 32'h0ABC);
        wr(`REG_CTRL, 32'h1);
        job(`CMD_WRITE, 16'h2345);
        wait_req();
        check(32'(n < `OSC_STAB_CYC), 32'h1);
        check(32'({flash_op, flash_addr, flash_wdata}), 32'h22345A5);
        wait_ev();
        check(rd, 32'h1);
        check(32'(irq), 32'h0);
        wr(`REG_EVMASK, 32'h7);
        repeat (2) @(posedge ref_clk);
        check(32'(irq), 32'h1);
        wr(`REG_EVENT, 32'h1);
        repeat (2) @(posedge ref_clk);
        check(32'(irq), 32'h0);
        // slow oscillator start when the cpu runs from the crystal
        xtal <= 1'b1;
        job(`CMD_BLOCK_ERASE, 16'h3000);
        wait_req();
        check(32'(n >= `OSC_STAB_CYC - 2), 32'h1);
        wait_ev();
        wr(`REG_EVENT, 32'h7);
        xtal <= 1'b0;
        // stop on a request, then resume; slow array leaves room
        delay <= 8'h3C;
        msk[1] <= 8'h01;
        job(`CMD_WRITE, 16'h2400);
        wait_req();
        flg[1] <= 8'h01;
        repeat (4) @(posedge ref_clk);
        check(32'(flash_req), 32'h1);
        flg[3] <= 8'h10;
        repeat (3) @(posedge ref_clk);
        check(32'(flash_req), 32'h0);
        flg <= '0;
        rdchk(`REG_STATUS, 32'h2, 32'h2);
        rdchk(`REG_EVENT, 32'h7, 32'h2);
        check(32'(irq), 32'h1);
        wr(`REG_EVENT, 32'h7);
        wr(`REG_CMD, 32'(`CMD_RESUME));
        wait_req();
        check(32'(flash_addr), 32'h2400);
        wait_ev();
        check(rd, 32'h1);
        wr(`REG_EVENT, 32'h7);
        delay <= 8'h04;
        msk <= '0;
        // new boot code into cluster 1 before the swap
        job(`CMD_WRITE, 16'h1000);
        wait_ev();
        check(rd, 32'h1);
        wr(`REG_EVENT, 32'h7);
        job(`CMD_SWAP_SET, 16'h0);
        wait_ev();
        check(rd, 32'h1);
        rdchk(`REG_STATUS, 32'hC, 32'h8);
        do_reset();
        rdchk(`REG_STATUS, 32'hC, 32'hC);
        for (int i = 0; i < 3; i++)
        begin
            cpu_addr <= din[i];
            repeat (2) @(posedge ref_clk);
            check(32'(phys_addr), 32'(dsw[i]));
        end
        wr(`REG_CTRL, 32'h1);
        job(`CMD_WRITE, 16'h0100);
        wait_ev();
        check(rd, 32'h1);
        wr(`REG_EVENT, 32'h7);
        job(`CMD_SWAP_CLR, 16'h0);
        wait_ev();
        check(rd, 32'h1);
        do_reset();
        rdchk(`REG_STATUS, 32'hC, 32'h0);
        cpu_addr <= 16'h0123;
        repeat (2) @(posedge ref_clk);
        check(32'(phys_addr), 32'h0123);
        // protections; set-only, so this comes last
        wr(`REG_CTRL, 32'h1);
        wr(`REG_SECURITY, 32'h7);
        rdchk(`REG_SECURITY, 32'h7, 32'h7);
        for (int i = 0; i < 7; i++)
        begin
            ext <= px[i];
            job(pc[i], pa[i]);
            wait_ev();
            check(rd, 32'(pe[i]));
            wr(`REG_EVENT, 32'h7);
        end
        ext <= 1'b0;
        pin <= 1'b0;
        job(`CMD_WRITE, 16'h2000);
        wait_ev();
        check(rd, 32'h4);
        pin <= 1'b1;
        close_out();
    end
endmodule
